/* File: design/sfl_loader.sv */
// Frequency command handler that loads the clock synthesizer from tables
// Overview of operation
// - A selection matches a table entry only on an exact character-for-character string match.
// - The external table is scanned first and the built-in table only when nothing external matches.
// - Entry parameters one to three go in order to the first feedback divider integer, numerator, denominator.
// - The same three values are also loaded into the second, unused feedback divider.
// - Without a fourth parameter every output divider integer gets 256.
// - Every output divider numerator is loaded with zero.
// - Every output divider denominator is loaded with one.
// - A fourth parameter, needed outside the 2M band, replaces the default output divider integer.
// - The built-in table always holds at least one entry so the scanner has something to walk.
// - The offset note is stored but never sent, and status shows it only once defined.
// - Broadcast-band selections from 87.5MHz to 108.0MHz are taken and work only via an external entry.
// - At most one synthesizer clock output is enabled at a time.
`timescale 1ns/100ps
`include "sfl_defines.svh"
module sfl_loader (
  input  wire logic                    clk_in,                // 50 MHz clock
  input  wire logic                    rst_in,                // Sync reset, high
  input  wire logic                    cmd_frequency_select_command_valid_in,     // Selection command strobe
  input  wire logic [63:0]             cmd_frequency_select_command_in,           // Requested frequency string
  input  wire logic [1:0]              cmd_out_sel_in,        // Clock output to enable
  input  wire logic                    cmd_offset_valid_in,   // Offset note command strobe
  input  wire logic [63:0]             cmd_offset_in,         // Offset note text
  input  wire logic                    cmd_stat_in,           // Status command strobe
  input  wire logic [7:0]              ext_count_in,          // Entries in external table
  output logic                         ext_rd_en_out,         // External table read
  output logic [7:0]                   ext_rd_addr_out,       // External entry index
  input  wire sfl_pkg::sfl_record_t    ext_rd_data_in,        // Entry, cycle after read
  output logic                         syn_wr_valid_out,      // Register write request
  output sfl_pkg::sfl_write_t          syn_wr_out,            // Register id and value
  input  wire logic                    syn_wr_ready_in,       // Write accepted
  output logic                         resp_valid_out,        // Selection done pulse
  output logic                         resp_ok_out,           // Selection loaded
  output logic                         resp_ext_out,          // Entry came from external
  output logic                         stat_valid_out,        // Status answer pulse
  output logic                         stat_offset_present_out, // Offset note defined
  output logic [63:0]                  stat_offset_out        // Offset note text
);
  // ----------------------------------------------------------------
  // Built-in table
  // ----------------------------------------------------------------
  // Kept at two entries; never drop below one, the scanner needs it
  function automatic sfl_pkg::sfl_record_t builtin_entry(input logic [7:0] idx);
    sfl_pkg::sfl_record_t r;
    r.frequency_select_command  = (idx == 8'h01) ? "146.520 " : "145.000 ";
    r.param = (idx == 8'h01) ? {"        ", "   F4240", "   3A980", "    13CC"} :
                               {"        ", "   F4240", "   70E40", "    13BF"};
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  sfl_pkg::sfl_state_t  state_reg;
  logic [63:0]          frequency_select_command_reg;
  logic [1:0]           sel_reg;
  logic [7:0]           count_reg;
  logic [7:0]           idx_reg;
  sfl_pkg::sfl_record_t match_reg;
  logic                 from_ext_reg;
  logic [3:0]           step_reg;
  logic                 offset_def_reg;
  logic [63:0]          offset_reg;
  logic [3:0][31:0]     pval;
  logic [3:0]           ppres;
  logic [3:0]           perr;
  sfl_pkg::sfl_record_t int_rec;
  logic                 parse_ok;
  sfl_pkg::sfl_write_t  wr_next;
  assign int_rec  = builtin_entry(idx_reg);
  // First three fields are mandatory, fourth optional
  assign parse_ok = (perr == 4'h0) && (ppres[2:0] == 3'h7);
  for (genvar g = 0; g < `SFL_NUM_PARAMS; g++) begin : gen_parse
    sfl_hex_parse u_parse (
      .ascii_in    (match_reg.param[g]),
      .value_out   (pval[g]),
      .present_out (ppres[g]),
      .error_out   (perr[g])
    );
  end

  // ----------------------------------------------------------------
  // Search and write sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_reg       <= sfl_pkg::SFL_IDLE;
      frequency_select_command_reg        <= 64'h0;
      sel_reg         <= 2'h0;
      count_reg       <= 8'h00;
      idx_reg         <= 8'h00;
      match_reg       <= '0;
      from_ext_reg    <= 1'b0;
      step_reg        <= 4'h0;
      ext_rd_en_out   <= 1'b0;
      ext_rd_addr_out <= 8'h00;
      resp_valid_out  <= 1'b0;
      resp_ok_out     <= 1'b0;
      resp_ext_out    <= 1'b0;
    end else begin
      resp_valid_out <= 1'b0;
      ext_rd_en_out  <= 1'b0;
      case (state_reg)
        sfl_pkg::SFL_IDLE: begin
          // no band gate, table contents decide
          if (cmd_frequency_select_command_valid_in) begin
            frequency_select_command_reg  <= cmd_frequency_select_command_in;
            sel_reg   <= cmd_out_sel_in;
            count_reg <= ext_count_in;
            idx_reg   <= 8'h00;
            state_reg <= (ext_count_in != 8'h00) ? sfl_pkg::SFL_EXT_RD : sfl_pkg::SFL_INT_CMP;
          end
        end
        sfl_pkg::SFL_EXT_RD: begin
          ext_rd_en_out   <= 1'b1;
          ext_rd_addr_out <= idx_reg;
          state_reg       <= sfl_pkg::SFL_EXT_WAIT;
        end
        sfl_pkg::SFL_EXT_WAIT: begin
          state_reg <= sfl_pkg::SFL_EXT_CMP;
        end
        sfl_pkg::SFL_EXT_CMP: begin
          if (ext_rd_data_in.frequency_select_command == frequency_select_command_reg) begin
            match_reg    <= ext_rd_data_in;
            from_ext_reg <= 1'b1;
            state_reg    <= sfl_pkg::SFL_PARSE;
          end else if (idx_reg + 8'h01 < count_reg) begin
            idx_reg   <= idx_reg + 8'h01;
            state_reg <= sfl_pkg::SFL_EXT_RD;
          end else begin
            idx_reg   <= 8'h00;
            state_reg <= sfl_pkg::SFL_INT_CMP;
          end
        end
        sfl_pkg::SFL_INT_CMP: begin
          // scan relies on a non-empty built-in table
          if (int_rec.frequency_select_command == frequency_select_command_reg) begin
            match_reg    <= int_rec;
            from_ext_reg <= 1'b0;
            state_reg    <= sfl_pkg::SFL_PARSE;
          end else if (idx_reg + 8'h01 < 8'(`SFL_BUILTIN_COUNT)) begin
            idx_reg <= idx_reg + 8'h01;
          end else begin
            resp_valid_out <= 1'b1;
            resp_ok_out    <= 1'b0;
            resp_ext_out   <= 1'b0;
            state_reg      <= sfl_pkg::SFL_DONE;
          end
        end
        sfl_pkg::SFL_PARSE: begin
          step_reg <= 4'h0;
          if (parse_ok) begin
            state_reg <= sfl_pkg::SFL_WRITE;
          end else begin
            resp_valid_out <= 1'b1;
            resp_ok_out    <= 1'b0;
            resp_ext_out   <= from_ext_reg;
            state_reg      <= sfl_pkg::SFL_DONE;
          end
        end
        sfl_pkg::SFL_WRITE: begin
          if (syn_wr_valid_out && syn_wr_ready_in) begin
            if (step_reg == `SFL_STEP_OE) begin
              resp_valid_out <= 1'b1;
              resp_ok_out    <= 1'b1;
              resp_ext_out   <= from_ext_reg;
              state_reg      <= sfl_pkg::SFL_DONE;
            end else begin
              step_reg <= step_reg + 4'h1;
            end
          end
        end
        sfl_pkg::SFL_DONE: begin
          state_reg <= sfl_pkg::SFL_IDLE;
        end
        default: begin
          state_reg <= sfl_pkg::SFL_IDLE;
        end
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Register write content per step
  // ----------------------------------------------------------------
  always_comb begin
    int k;
    int f;
    k = 0;
    f = 0;
    wr_next = '0;
    if (step_reg < `SFL_STEP_PLLB) begin
      wr_next.reg_id = `SFL_REG_PLLA + 8'(step_reg);
      wr_next.data   = pval[step_reg[1:0]];
    end else if (step_reg < `SFL_STEP_OUT) begin
      wr_next.reg_id = `SFL_REG_PLLB + 8'(step_reg - `SFL_STEP_PLLB);
      wr_next.data   = pval[2'(step_reg - `SFL_STEP_PLLB)];
    end else if (step_reg < `SFL_STEP_OE) begin
      k = (int'(step_reg) - int'(`SFL_STEP_OUT)) / 3;
      f = (int'(step_reg) - int'(`SFL_STEP_OUT)) % 3;
      wr_next.reg_id = `SFL_REG_OUT_BASE + 8'(k) * `SFL_REG_OUT_STRIDE + 8'(f);
      if (f == 0) begin
        wr_next.data = ppres[3] ? pval[3] : `SFL_OUT_INT_DEF;
      end else if (f == 1) begin
        wr_next.data = `SFL_OUT_NUM_DEF;
      end else begin
        wr_next.data = `SFL_OUT_DEN_DEF;
      end
    end else begin
      wr_next.reg_id = `SFL_REG_OE;
      wr_next.data   = 32'h0000_0001 << sel_reg;
    end
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      syn_wr_valid_out <= 1'b0;
      syn_wr_out       <= '0;
    end else if (state_reg == sfl_pkg::SFL_WRITE && !(syn_wr_valid_out && syn_wr_ready_in)) begin
      syn_wr_valid_out <= 1'b1;
      syn_wr_out       <= wr_next;
    end else begin
      syn_wr_valid_out <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // Offset note and status
  // ----------------------------------------------------------------
  // note kept locally, never written out
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      offset_def_reg          <= 1'b0;
      offset_reg              <= 64'h0;
      stat_valid_out          <= 1'b0;
      stat_offset_present_out <= 1'b0;
      stat_offset_out         <= 64'h0;
    end else begin
      if (cmd_offset_valid_in) begin
        offset_def_reg <= 1'b1;
        offset_reg     <= cmd_offset_in;
      end
      stat_valid_out <= cmd_stat_in;
      if (cmd_stat_in) begin
        stat_offset_present_out <= offset_def_reg;
        stat_offset_out         <= offset_def_reg ? offset_reg : 64'h0;
      end
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking sfl_cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic out_div_wr;
  assign out_div_wr = syn_wr_valid_out && syn_wr_out.reg_id >= `SFL_REG_OUT_BASE && syn_wr_out.reg_id < `SFL_REG_OE;
  a_exact_match: assert property (state_reg == sfl_pkg::SFL_PARSE |-> match_reg.frequency_select_command == frequency_select_command_reg)
    else $error("parsed entry string differs from request");
  a_ext_before_int: assert property ($rose(state_reg == sfl_pkg::SFL_INT_CMP)
    && $past(state_reg) == sfl_pkg::SFL_EXT_CMP |-> $past(idx_reg) + 8'h01 >= count_reg)
    else $error("built-in table used before external scan finished");
  a_plla_order: assert property (syn_wr_valid_out && syn_wr_out.reg_id < `SFL_REG_PLLB |->
    syn_wr_out.data == pval[syn_wr_out.reg_id[1:0]]) else $error("first divider loaded with wrong field");
  a_pllb_mirror: assert property (syn_wr_valid_out && syn_wr_out.reg_id >= `SFL_REG_PLLB
    && syn_wr_out.reg_id < `SFL_REG_OUT_BASE |-> syn_wr_out.data == pval[2'(syn_wr_out.reg_id - `SFL_REG_PLLB)])
    else $error("second divider differs from first");
  a_out_int_value: assert property (out_div_wr && syn_wr_out.reg_id[1:0] == 2'h0 |->
    syn_wr_out.data == (ppres[3] ? pval[3] : `SFL_OUT_INT_DEF)) else $error("output divider integer wrong");
  a_out_num_zero: assert property (out_div_wr && syn_wr_out.reg_id[1:0] == 2'h1 |->
    syn_wr_out.data == `SFL_OUT_NUM_DEF) else $error("output divider numerator not zero");
  a_out_den_one: assert property (out_div_wr && syn_wr_out.reg_id[1:0] == 2'h2 |->
    syn_wr_out.data == `SFL_OUT_DEN_DEF) else $error("output divider denominator not one");
  a_one_output: assert property (syn_wr_valid_out && syn_wr_out.reg_id == `SFL_REG_OE |->
    $onehot(syn_wr_out.data)) else $error("more than one clock output enabled");
  a_offset_shown: assert property (cmd_stat_in && !offset_def_reg |=>
    stat_valid_out && !stat_offset_present_out) else $error("offset reported before defined");
  a_fail_no_write: assert property (resp_valid_out && !resp_ok_out |->
    !syn_wr_valid_out && $past(state_reg) != sfl_pkg::SFL_WRITE)
    else $error("failed selection touched synthesizer");
  a_write_bounded: assert property (state_reg == sfl_pkg::SFL_PARSE && parse_ok |=>
    ##[1:2] syn_wr_valid_out) else $error("write sequence did not start after match");
  c_ext_match: cover property (resp_valid_out && resp_ok_out && resp_ext_out);
  c_int_match: cover property (resp_valid_out && resp_ok_out && !resp_ext_out);
  c_no_match:  cover property (resp_valid_out && !resp_ok_out);
  c_fourth:    cover property (syn_wr_valid_out && ppres[3]);
endmodule

/* File: design/sfl_defines.svh */
// Constants for the frequency table synthesizer loader
`ifndef SFL_DEFINES_SVH
`define SFL_DEFINES_SVH

`define SFL_CHARS          8
`define SFL_NUM_PARAMS     4
`define SFL_NUM_OUT        3
`define SFL_BUILTIN_COUNT  2
`define SFL_IDX_W          8
`define SFL_STEPS          16
`define SFL_STEP_PLLB      4'h3
`define SFL_STEP_OUT       4'h6
`define SFL_STEP_OE        4'hF

`define SFL_REG_PLLA       8'h00
`define SFL_REG_PLLB       8'h03
`define SFL_REG_OUT_BASE   8'h10
`define SFL_REG_OUT_STRIDE 8'h04
`define SFL_REG_OE         8'h20

`define SFL_OUT_INT_DEF    32'h0000_0100
`define SFL_OUT_NUM_DEF    32'h0000_0000
`define SFL_OUT_DEN_DEF    32'h0000_0001
`define SFL_ASCII_SPACE    8'h20

`endif

/* File: design/sfl_pkg.sv */
// Types for the frequency table synthesizer loader
package sfl_pkg;

  typedef struct packed {
    logic [63:0]      frequency_select_command;    // ASCII, left justified, space padded
    logic [3:0][63:0] param;   // ASCII hex, right justified, space padded
  } sfl_record_t;

  typedef struct packed {
    logic [7:0]  reg_id;
    logic [31:0] data;
  } sfl_write_t;

  typedef enum logic [2:0] {
    SFL_IDLE     = 3'b000,
    SFL_EXT_RD   = 3'b001,
    SFL_EXT_WAIT = 3'b010,
    SFL_EXT_CMP  = 3'b011,
    SFL_INT_CMP  = 3'b100,
    SFL_PARSE    = 3'b101,
    SFL_WRITE    = 3'b110,
    SFL_DONE     = 3'b111
  } sfl_state_t;

endpackage

/* File: design/sfl_hex_parse.sv */
// ASCII hex field to binary value converter
`timescale 1ns/100ps
`include "sfl_defines.svh"
module sfl_hex_parse (
  input  wire logic [63:0] ascii_in,   // Field, space padded
  output logic      [31:0] value_out,  // Parsed value
  output logic             present_out,// Field holds digits
  output logic             error_out   // Illegal character
);
  logic [7:0] ch;
  logic [3:0] nib;

  always_comb begin
    value_out   = 32'h0000_0000;
    present_out = 1'b0;
    error_out   = 1'b0;
    ch          = 8'h00;
    nib         = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      ch = ascii_in[i*8 +: 8];
      if (ch >= 8'h30 && ch <= 8'h39) begin
        nib = 4'(ch - 8'h30);
      end else if (ch >= 8'h41 && ch <= 8'h46) begin
        nib = 4'(ch - 8'h37);
      end else if (ch >= 8'h61 && ch <= 8'h66) begin
        nib = 4'(ch - 8'h57);
      end else begin
        nib = 4'h0;
      end
      if (ch == `SFL_ASCII_SPACE) begin
        // Padding is only legal before the first digit
        if (present_out) begin
          error_out = 1'b1;
        end
      end else if ((ch >= 8'h30 && ch <= 8'h39) || (ch >= 8'h41 && ch <= 8'h46) ||
                   (ch >= 8'h61 && ch <= 8'h66)) begin
        present_out = 1'b1;
        value_out   = {value_out[27:0], nib};
      end else begin
        error_out = 1'b1;
      end
    end
  end
endmodule

/* File: dv/sfl_partner_model.sv */
// Far-side model: external entry table and synthesizer register port
`timescale 1ns/100ps
module sfl_partner_model (
  input  wire logic                clk_in,       // Bench clock
  input  wire logic                slow_in,      // Stall writes
  input  wire logic                rd_en_in,     // Entry read
  input  wire logic [7:0]          rd_addr_in,   // Entry index
  output sfl_pkg::sfl_record_t     rd_data_out,  // Entry data
  input  wire logic                wr_valid_in,  // Write request
  input  wire sfl_pkg::sfl_write_t wr_in,        // Write payload
  output logic                     wr_ready_out  // Write accept
);
  sfl_pkg::sfl_record_t entry_mem [3];
  sfl_pkg::sfl_write_t  wr_q      [$];
  logic [1:0]           stall_cnt;

  initial begin
    // Shadows a built-in entry, so the external one must win
    entry_mem[0] = '{frequency_select_command: "145.000 ", param: '{"        ", "   F4240", "   70E40", "    13BF"}};
    entry_mem[1] = '{frequency_select_command: "50.500  ", param: '{"     400", "   F4240", "   61A7F", "     D26"}};
    entry_mem[2] = '{frequency_select_command: "98.100  ", param: '{"      80", "   F4240", "   3C4D5", "    1A2B"}};
    rd_data_out  = '0;
    wr_ready_out = 1'b0;
    stall_cnt    = 2'h0;
  end

  always @(posedge clk_in) begin
    if (rd_en_in && rd_addr_in < 8'h03) begin
      rd_data_out <= entry_mem[rd_addr_in[1:0]];
    end else begin
      // Stale data turns over every cycle so a late sample is caught
      rd_data_out <= ~rd_data_out;
    end
    if (wr_valid_in && wr_ready_out) begin
      wr_q.push_back(wr_in);
    end
    stall_cnt    <= stall_cnt + 2'h1;
    wr_ready_out <= !slow_in || (stall_cnt == 2'h3);
  end
endmodule

/* File: dv/test_frequency_select_command_table_synth_loader.sv */
// Self-checking bench for the frequency table synthesizer loader
`timescale 1ns/100ps
`include "sfl_defines.svh"
module test_frequency_select_command_table_synth_loader;
  logic                 clk_in, rst_in, slow;
  logic                 cmd_frequency_select_command_valid_in, cmd_offset_valid_in, cmd_stat_in;
  logic [1:0]           cmd_out_sel_in;
  logic [63:0]          cmd_frequency_select_command_in, cmd_offset_in, stat_offset_out;
  logic [7:0]           ext_count_in, ext_rd_addr_out;
  logic                 ext_rd_en_out, syn_wr_valid_out, syn_wr_ready_in;
  logic                 resp_valid_out, resp_ok_out, resp_ext_out, stat_valid_out, stat_offset_present_out;
  sfl_pkg::sfl_record_t ext_rd_data_in;
  sfl_pkg::sfl_write_t  syn_wr_out;
  int                   mismatches = 0;
  int                   total_checks = 0;

  sfl_loader u_dut (.clk_in(clk_in), .rst_in(rst_in), .cmd_frequency_select_command_valid_in(cmd_frequency_select_command_valid_in),
    .cmd_frequency_select_command_in(cmd_frequency_select_command_in), .cmd_out_sel_in(cmd_out_sel_in), .cmd_offset_valid_in(cmd_offset_valid_in),
    .cmd_offset_in(cmd_offset_in), .cmd_stat_in(cmd_stat_in), .ext_count_in(ext_count_in),
    .ext_rd_en_out(ext_rd_en_out), .ext_rd_addr_out(ext_rd_addr_out), .ext_rd_data_in(ext_rd_data_in),
    .syn_wr_valid_out(syn_wr_valid_out), .syn_wr_out(syn_wr_out), .syn_wr_ready_in(syn_wr_ready_in),
    .resp_valid_out(resp_valid_out), .resp_ok_out(resp_ok_out), .resp_ext_out(resp_ext_out),
    .stat_valid_out(stat_valid_out), .stat_offset_present_out(stat_offset_present_out),
    .stat_offset_out(stat_offset_out));

  sfl_partner_model u_partner (.clk_in(clk_in), .slow_in(slow), .rd_en_in(ext_rd_en_out),
    .rd_addr_in(ext_rd_addr_out), .rd_data_out(ext_rd_data_in), .wr_valid_in(syn_wr_valid_out),
    .wr_in(syn_wr_out), .wr_ready_out(syn_wr_ready_in));

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  // ----------------------------------------
  // Compare and report
  // ----------------------------------------
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // One selection; p[3] of zero means no fourth param; poke sends one extra 50.500 command while busy
  task automatic select(input logic [63:0] f, input logic [1:0] sel, input logic [7:0] cnt, input logic ok,
                        input logic ext, input logic [3:0][31:0] p, input logic poke);
    int                  n;
    int                  m;
    sfl_pkg::sfl_write_t w;
    repeat (2) @(negedge clk_in);
    u_partner.wr_q.delete();
    cmd_frequency_select_command_in       = f;
    cmd_out_sel_in    = sel;
    ext_count_in      = cnt;
    cmd_frequency_select_command_valid_in = 1'b1;
    @(negedge clk_in);
    cmd_frequency_select_command_valid_in = 1'b0;
    n = 0;
    while (resp_valid_out !== 1'b1) begin
      cmd_frequency_select_command_valid_in = poke && (n == 4);
      cmd_frequency_select_command_in       = poke ? "50.500  " : f;
      n++;
      if (n > 3000) begin
        mismatches++;
        $display("mismatch resp_wait expected pulse seen none");
        print_verdict();
      end
      @(negedge clk_in);
    end
    check("resp_ok", resp_ok_out, ok);
    if (ok) check("resp_ext", resp_ext_out, ext);
    check("write_count", u_partner.wr_q.size(), ok ? 16 : 0);
    for (int i = 0; i < 16 && i < u_partner.wr_q.size(); i++) begin
      w = u_partner.wr_q[i];
      m = (i - 6) % 3;
      if (i < 6) begin
        check("pll_reg", w.reg_id, i);
        if (i >= 3) check("pll_b_data", w.data, u_partner.wr_q[i-3].data);
        else check("pll_a_data", w.data, p[i]);
      end else if (i < 15) begin
        check("out_reg", w.reg_id, `SFL_REG_OUT_BASE + `SFL_REG_OUT_STRIDE * ((i - 6) / 3) + m);
        if (m == 0) check("out_int", w.data, (p[3] != 0) ? p[3] : `SFL_OUT_INT_DEF);
        else check("out_frac", w.data, m - 1);
      end else begin
        check("oe_reg", w.reg_id, `SFL_REG_OE);
        check("oe_data", w.data, 32'h1 << sel);
      end
    end
    // Nothing more may come from the ignored busy command
    repeat (4) begin
      @(negedge clk_in);
      check("extra_resp", resp_valid_out, 1'b0);
    end
    check("extra_writes", u_partner.wr_q.size(), ok ? 16 : 0);
  endtask

  task automatic status(input logic present, input logic [63:0] txt);
    @(negedge clk_in);
    cmd_stat_in = 1'b1;
    @(negedge clk_in);
    cmd_stat_in = 1'b0;
    check("stat_valid", stat_valid_out, 1'b1);
    check("stat_present", stat_offset_present_out, present);
    check("stat_text", stat_offset_out, txt);
  endtask

  task automatic offset_note();
    u_partner.wr_q.delete();
    @(negedge clk_in);
    cmd_offset_in       = "+1200 Hz";
    cmd_offset_valid_in = 1'b1;
    @(negedge clk_in);
    cmd_offset_valid_in = 1'b0;
    repeat (5) @(negedge clk_in);
    check("offset_writes", u_partner.wr_q.size(), 0);
    status(1'b1, "+1200 Hz");
  endtask

  initial begin
    rst_in              = 1'b1;
    slow                = 1'b0;
    cmd_frequency_select_command_valid_in   = 1'b0;
    cmd_offset_valid_in = 1'b0;
    cmd_stat_in         = 1'b0;
    cmd_out_sel_in      = 2'h0;
    cmd_frequency_select_command_in         = '0;
    cmd_offset_in       = '0;
    ext_count_in        = 8'h00;
    repeat (2) @(negedge clk_in);
    rst_in = 1'b0;
    check("rst_wr_valid", syn_wr_valid_out, 1'b0);
    check("rst_resp", resp_valid_out, 1'b0);
    check("rst_rd_en", ext_rd_en_out, 1'b0);
    status(1'b0, 64'h0);
    select("145.000 ", 2'h0, 8'h03, 1'b1, 1'b1, {32'h0, 32'hF4240, 32'h70E40, 32'h13BF}, 1'b1);
    slow = 1'b1;
    select("50.500  ", 2'h2, 8'h03, 1'b1, 1'b1, {32'h400, 32'hF4240, 32'h61A7F, 32'hD26}, 1'b0);
    slow = 1'b0;
    select("98.100  ", 2'h1, 8'h03, 1'b1, 1'b1, {32'h80, 32'hF4240, 32'h3C4D5, 32'h1A2B}, 1'b0);
    select("98.100  ", 2'h1, 8'h02, 1'b0, 1'b0, '0, 1'b0);
    select("146.520 ", 2'h1, 8'h03, 1'b1, 1'b0, {32'h0, 32'hF4240, 32'h3A980, 32'h13CC}, 1'b0);
    select("145.00  ", 2'h0, 8'h03, 1'b0, 1'b0, '0, 1'b0);
    offset_note();
    print_verdict();
  end
endmodule
